// File: design/uem_defines.vh
// Shared constants for the USB endpoint mode engine
`ifndef UEM_DEFINES_VH
`define UEM_DEFINES_VH

// ==========================================
// Endpoint modes
`define UEM_M_DISABLE   4'h0
`define UEM_M_NAK_IO    4'h1
`define UEM_M_STAT_OUT  4'h2
`define UEM_M_STALL_IO  4'h3
`define UEM_M_IGN_IO    4'h4
`define UEM_M_ISO_OUT   4'h5
`define UEM_M_STAT_IN   4'h6
`define UEM_M_ISO_IN    4'h7
`define UEM_M_NAK_OUT   4'h8
`define UEM_M_ACK_OUT   4'h9
`define UEM_M_NAK_OSI   4'hA
`define UEM_M_ACK_OSI   4'hB
`define UEM_M_NAK_IN    4'hC
`define UEM_M_ACK_IN    4'hD
`define UEM_M_NAK_ISO   4'hE
`define UEM_M_ACK_ISO   4'hF

// ==========================================
// Token kinds from the serial_engine
`define UEM_PID_SETUP   2'h1
`define UEM_PID_IN      2'h2
`define UEM_PID_OUT     2'h3

// ==========================================
// Responses to the serial_engine
`define UEM_R_ACK       3'h1
`define UEM_R_NAK       3'h2
`define UEM_R_STALL     3'h3
`define UEM_R_TX0       3'h4
`define UEM_R_TXCNT     3'h5

// ==========================================
// Register map and fields
`define UEM_A_MODE0     4'h0
`define UEM_A_CNT0      4'h4
`define UEM_B_ST_SETUP  7
`define UEM_B_ST_IN     6
`define UEM_B_ST_OUT    5
`define UEM_B_ST_ACK    4
`define UEM_B_TOG       7
`define UEM_B_DVAL      6
`define UEM_RST_MODE    8'h00
`define UEM_RST_CNT     8'h00

// ==========================================
// Packet limits
`define UEM_MAX_PKT     4'hA
`define UEM_STAT_LEN    4'h2

`endif

// File: design/uem_engine.v
// Endpoint mode engine: token answers, mode moves, status and lock
`timescale 1ns/10ps
`include "uem_defines.vh"

// Overview of operation
// - Disabled endpoints ignore Setup, In and Out, with no interrupt.
// - Modes reset to disabled and stay so until firmware writes.
// - Accepted Setup forces the endpoint mode to NAK both directions.
// - Every Setup-accepting mode ACKs a valid Setup data packet.
// - 0010 stalls In, checks Out; 0011 stalls both; 0100 ignores both.
// - 0110 accepts Setup, sends zero length on In, stalls Out.
// - Isochronous modes ignore Setup; 0101 takes Out, 0111 sends count.
// - 1001 ACKs Out then 1000; 1011 also takes Setup, TX0, then 1010.
// - 1101 sends count then 1100; 1111 takes Setup, checks Out, sends count then 1110.
// - ACK-ending modes move to the matching NAKing mode.
// - Status check passes only on zero length data with toggle 1.
// - Handshakes only for valid transactions, silence otherwise.
// - Interrupt on completed valid transaction or corrupted receive buffer.
// - Data packet valid only if count with CRC is at most 10 and clean.
// - Modes not accepting Setup ignore Setup tokens completely.
// - Out endpoints ignore In tokens; In endpoints ignore Out tokens.
// - In and Out status bits update when the transaction finishes.
// - Setup status bit updates at start of the following data phase.
// - ACKed endpoint-0 transaction locks mode and count against writes.
// - Lock releases on CPU read of endpoint-0 mode or count after the transaction has completed.
// - Control endpoints carry Setup, In and Out status bits.
// - Any endpoint in a Setup-accepting mode acts as control endpoint.
module uem_engine #(
  parameter EP_NUM = 3
) (
  input  wire              i_mclk,
  input  wire              i_sys_rst,
  input  wire              i_tok_stb,
  input  wire [1:0]        i_tok_pid,
  input  wire [1:0]        i_tok_ep,
  input  wire              i_dat_start,
  input  wire              i_dat_stb,
  input  wire [3:0]        i_dat_cnt,
  input  wire              i_dat_ok,
  input  wire              i_dat_tog,
  input  wire              i_hs_stb,
  input  wire              i_hs_ack,
  input  wire [3:0]        i_reg_addr,
  input  wire [7:0]        i_reg_wdata,
  input  wire              i_reg_wr,
  input  wire              i_reg_rd,
  output reg  [7:0]        o_reg_rdata,
  output reg               o_resp_stb,
  output reg  [2:0]        o_resp_code,
  output reg  [3:0]        o_tx_len,
  output reg  [EP_NUM-1:0] o_ep_int,
  output wire              o_ep0_locked
);

  // ==========================================
  // States and answer classes
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_WDATA = 2'h1;
  localparam [1:0] ST_WHS   = 2'h2;

  localparam [2:0] C_IGN   = 3'h0;
  localparam [2:0] C_NAK   = 3'h1;
  localparam [2:0] C_STALL = 3'h2;
  localparam [2:0] C_ACK   = 3'h3;
  localparam [2:0] C_CHECK = 3'h4;
  localparam [2:0] C_ISO   = 3'h5;
  localparam [2:0] C_TX0   = 3'h6;
  localparam [2:0] C_TXCNT = 3'h7;

  localparam [2:0] EP_LIM = EP_NUM;

  // ==========================================
  // Mode decode
  function accepts_setup;
    input [3:0] m;
    begin
      case (m)
        `UEM_M_NAK_IO, `UEM_M_STAT_OUT, `UEM_M_STALL_IO, `UEM_M_IGN_IO,
        `UEM_M_STAT_IN, `UEM_M_NAK_OSI, `UEM_M_ACK_OSI, `UEM_M_NAK_ISO,
        `UEM_M_ACK_ISO: accepts_setup = 1'b1;
        default: accepts_setup = 1'b0;
      endcase
    end
  endfunction

  function [2:0] in_class;
    input [3:0] m;
    begin
      case (m)
        `UEM_M_NAK_IO, `UEM_M_NAK_IN, `UEM_M_NAK_ISO: in_class = C_NAK;
        `UEM_M_STAT_OUT, `UEM_M_STALL_IO: in_class = C_STALL;
        `UEM_M_STAT_IN, `UEM_M_NAK_OSI, `UEM_M_ACK_OSI: in_class = C_TX0;
        `UEM_M_ISO_IN, `UEM_M_ACK_IN, `UEM_M_ACK_ISO: in_class = C_TXCNT;
        default: in_class = C_IGN;
      endcase
    end
  endfunction

  function [2:0] out_class;
    input [3:0] m;
    begin
      case (m)
        `UEM_M_NAK_IO, `UEM_M_NAK_OUT, `UEM_M_NAK_OSI: out_class = C_NAK;
        `UEM_M_STALL_IO, `UEM_M_STAT_IN: out_class = C_STALL;
        `UEM_M_ACK_OUT, `UEM_M_ACK_OSI: out_class = C_ACK;
        `UEM_M_STAT_OUT, `UEM_M_NAK_ISO, `UEM_M_ACK_ISO: out_class = C_CHECK;
        `UEM_M_ISO_OUT: out_class = C_ISO;
        default: out_class = C_IGN;
      endcase
    end
  endfunction

  // ==========================================
  // State and per-endpoint storage
  reg  [1:0]          state_reg;
  reg  [1:0]          state_next;
  reg  [1:0]          pend_pid_reg;
  reg  [1:0]          pend_ep_reg;
  reg  [2:0]          pend_cls_reg;
  reg  [1:0]          pend_pid_next;
  reg  [1:0]          pend_ep_next;
  reg  [2:0]          pend_cls_next;
  wire [EP_NUM*8-1:0] mode_all;
  wire [EP_NUM*8-1:0] cnt_all;
  wire [1:0]          sel_ep;
  wire [3:0]          mode_cur;
  wire [3:0]          cnt_cur;
  wire                tok_ep_ok;
  wire                pkt_valid;
  wire                stat_pass;
  wire                busy;
  wire                rd_ep0;

  reg                 hw_mode_ld;
  reg  [3:0]          hw_mode;
  reg  [3:0]          hw_stat;
  reg                 hw_cnt_ld;
  reg                 hw_dval;
  reg                 resp_stb_next;
  reg  [2:0]          resp_code_next;
  reg  [3:0]          tx_len_next;
  reg                 int_next;
  reg                 lock_set;

  assign sel_ep    = i_tok_stb ? i_tok_ep : pend_ep_reg;
  assign mode_cur  = mode_all[sel_ep*8 +: 4];
  assign cnt_cur   = cnt_all[sel_ep*8 +: 4];
  assign tok_ep_ok = ({1'b0, i_tok_ep} < EP_LIM);
  assign pkt_valid = i_dat_ok && (i_dat_cnt <= `UEM_MAX_PKT);
  // Zero data bytes means only the two CRC bytes arrive
  assign stat_pass = (i_dat_cnt == `UEM_STAT_LEN) && i_dat_tog;
  assign busy      = (state_reg != ST_IDLE) || i_tok_stb;

  // ==========================================
  // Transaction sequencing and answer decode
  always @* begin
    state_next     = state_reg;
    pend_pid_next  = pend_pid_reg;
    pend_ep_next   = pend_ep_reg;
    pend_cls_next  = pend_cls_reg;
    hw_mode_ld     = 1'b0;
    hw_mode        = mode_cur;
    hw_stat        = 4'h0;
    hw_cnt_ld      = 1'b0;
    hw_dval        = 1'b0;
    resp_stb_next  = 1'b0;
    resp_code_next = o_resp_code;
    tx_len_next    = o_tx_len;
    int_next       = 1'b0;
    lock_set       = 1'b0;
    // A fresh token always wins: the host has given up on any older one
    if (i_tok_stb) begin
      state_next    = ST_IDLE;
      pend_pid_next = i_tok_pid;
      pend_ep_next  = i_tok_ep;
      if (tok_ep_ok && mode_cur != `UEM_M_DISABLE) begin
        case (i_tok_pid)
          `UEM_PID_SETUP: begin
            if (accepts_setup(mode_cur)) begin
              state_next = ST_WDATA;
            end
          end
          `UEM_PID_OUT: begin
            pend_cls_next = out_class(mode_cur);
            if (out_class(mode_cur) != C_IGN) begin
              state_next = ST_WDATA;
            end
          end
          `UEM_PID_IN: begin
            pend_cls_next = in_class(mode_cur);
            case (in_class(mode_cur))
              C_NAK: begin
                resp_stb_next  = 1'b1;
                resp_code_next = `UEM_R_NAK;
                hw_stat[`UEM_B_ST_IN - 4] = 1'b1;
                int_next       = 1'b1;
              end
              C_STALL: begin
                resp_stb_next  = 1'b1;
                resp_code_next = `UEM_R_STALL;
                hw_stat[`UEM_B_ST_IN - 4] = 1'b1;
                int_next       = 1'b1;
                hw_mode_ld     = 1'b1;
                hw_mode        = `UEM_M_STALL_IO;
              end
              C_TX0: begin
                resp_stb_next  = 1'b1;
                resp_code_next = `UEM_R_TX0;
                tx_len_next    = 4'h0;
                state_next     = ST_WHS;
              end
              C_TXCNT: begin
                resp_stb_next  = 1'b1;
                resp_code_next = `UEM_R_TXCNT;
                tx_len_next    = cnt_cur;
                // Isochronous data gets no handshake back
                if (mode_cur == `UEM_M_ISO_IN) begin
                  hw_stat[`UEM_B_ST_IN - 4] = 1'b1;
                  int_next = 1'b1;
                end else begin
                  state_next = ST_WHS;
                end
              end
              default: begin
                state_next = ST_IDLE;
              end
            endcase
          end
          default: begin
            state_next = ST_IDLE;
          end
        endcase
      end
    end else begin
      case (state_reg)
        ST_WDATA: begin
          if (i_dat_start && pend_pid_reg == `UEM_PID_SETUP) begin
            hw_stat[`UEM_B_ST_SETUP - 4] = 1'b1;
          end
          if (i_dat_stb) begin
            state_next = ST_IDLE;
            if (pend_pid_reg == `UEM_PID_SETUP) begin
              hw_cnt_ld = 1'b1;
              hw_dval   = pkt_valid;
              int_next  = 1'b1;
              if (pkt_valid) begin
                resp_stb_next  = 1'b1;
                resp_code_next = `UEM_R_ACK;
                hw_stat[`UEM_B_ST_ACK - 4] = 1'b1;
                hw_mode_ld     = 1'b1;
                hw_mode        = `UEM_M_NAK_IO;
                lock_set       = (pend_ep_reg == 2'h0);
              end
            end else begin
              case (pend_cls_reg)
                C_NAK: begin
                  if (pkt_valid) begin
                    resp_stb_next  = 1'b1;
                    resp_code_next = `UEM_R_NAK;
                    hw_stat[`UEM_B_ST_OUT - 4] = 1'b1;
                    int_next       = 1'b1;
                  end
                end
                C_STALL: begin
                  if (pkt_valid) begin
                    resp_stb_next  = 1'b1;
                    resp_code_next = `UEM_R_STALL;
                    hw_stat[`UEM_B_ST_OUT - 4] = 1'b1;
                    int_next       = 1'b1;
                    hw_mode_ld     = 1'b1;
                    hw_mode        = `UEM_M_STALL_IO;
                  end
                end
                C_ISO, C_ACK: begin
                  // Buffer is written either way, so flag corruption
                  hw_cnt_ld = 1'b1;
                  hw_dval   = pkt_valid;
                  hw_stat[`UEM_B_ST_OUT - 4] = 1'b1;
                  int_next  = 1'b1;
                  if (pkt_valid && pend_cls_reg == C_ACK) begin
                    resp_stb_next  = 1'b1;
                    resp_code_next = `UEM_R_ACK;
                    hw_stat[`UEM_B_ST_ACK - 4] = 1'b1;
                    hw_mode_ld     = 1'b1;
                    hw_mode        = {mode_cur[3:1], 1'b0};
                    lock_set       = (pend_ep_reg == 2'h0);
                  end
                end
                C_CHECK: begin
                  if (pkt_valid) begin
                    hw_cnt_ld      = 1'b1;
                    hw_dval        = 1'b1;
                    hw_stat[`UEM_B_ST_OUT - 4] = 1'b1;
                    int_next       = 1'b1;
                    resp_stb_next  = 1'b1;
                    if (stat_pass) begin
                      resp_code_next = `UEM_R_ACK;
                      hw_stat[`UEM_B_ST_ACK - 4] = 1'b1;
                      lock_set       = (pend_ep_reg == 2'h0);
                    end else begin
                      resp_code_next = `UEM_R_STALL;
                      hw_mode_ld     = 1'b1;
                      hw_mode        = `UEM_M_STALL_IO;
                    end
                  end
                end
                default: begin
                  state_next = ST_IDLE;
                end
              endcase
            end
          end
        end
        ST_WHS: begin
          if (i_hs_stb) begin
            state_next = ST_IDLE;
            hw_stat[`UEM_B_ST_IN - 4] = 1'b1;
            int_next   = 1'b1;
            if (i_hs_ack) begin
              hw_stat[`UEM_B_ST_ACK - 4] = 1'b1;
              lock_set = (pend_ep_reg == 2'h0);
              if (mode_cur == `UEM_M_ACK_IN || mode_cur == `UEM_M_ACK_ISO) begin
                hw_mode_ld = 1'b1;
                hw_mode    = {mode_cur[3:1], 1'b0};
              end
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg    <= ST_IDLE;
      pend_pid_reg <= 2'h0;
      pend_ep_reg  <= 2'h0;
      pend_cls_reg <= C_IGN;
      o_resp_stb   <= 1'b0;
      o_resp_code  <= 3'h0;
      o_tx_len     <= 4'h0;
      o_ep_int     <= {EP_NUM{1'b0}};
    end else begin
      state_reg    <= state_next;
      pend_pid_reg <= pend_pid_next;
      pend_ep_reg  <= pend_ep_next;
      pend_cls_reg <= pend_cls_next;
      o_resp_stb   <= resp_stb_next;
      o_resp_code  <= resp_code_next;
      o_tx_len     <= tx_len_next;
      o_ep_int     <= int_next ? ({{(EP_NUM-1){1'b0}}, 1'b1} << sel_ep)
                               : {EP_NUM{1'b0}};
    end
  end

  // ==========================================
  // Endpoint registers and CPU access
  genvar g;
  generate
    for (g = 0; g < EP_NUM; g = g + 1) begin : g_ep
      wire here;
      wire blk;
      assign here = (sel_ep == g);
      // Write lock covers endpoint 0 only
      assign blk  = (g == 0) && o_ep0_locked;
      uem_ep_regs u_regs (
        .i_mclk        (i_mclk),
        .i_sys_rst     (i_sys_rst),
        .i_cpu_wr_mode (i_reg_wr && !blk && i_reg_addr == `UEM_A_MODE0 + g),
        .i_cpu_wr_cnt  (i_reg_wr && !blk && i_reg_addr == `UEM_A_CNT0 + g),
        .i_wdata       (i_reg_wdata),
        .i_hw_mode_ld  (hw_mode_ld && here),
        .i_hw_mode     (hw_mode),
        .i_hw_stat     (here ? hw_stat : 4'h0),
        .i_hw_cnt_ld   (hw_cnt_ld && here),
        .i_hw_cnt      (i_dat_cnt),
        .i_hw_tog      (i_dat_tog),
        .i_hw_dval     (hw_dval),
        .o_mode_reg    (mode_all[g*8 +: 8]),
        .o_cnt_reg     (cnt_all[g*8 +: 8])
      );
    end
  endgenerate

  assign rd_ep0 = i_reg_rd &&
                  (i_reg_addr == `UEM_A_MODE0 || i_reg_addr == `UEM_A_CNT0);

  // Reading while a transaction runs leaves the lock set
  uem_lock u_lock (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_set     (lock_set),
    .i_rd      (rd_ep0),
    .i_busy    (busy),
    .o_locked  (o_ep0_locked)
  );

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= 8'h00;
      if (i_reg_addr[1:0] < EP_LIM[1:0] && i_reg_addr[3] == 1'b0) begin
        o_reg_rdata <= i_reg_addr[2] ? cnt_all[i_reg_addr[1:0]*8 +: 8]
                                     : mode_all[i_reg_addr[1:0]*8 +: 8];
      end
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

endmodule // uem_engine

// File: design/uem_ep_regs.v
// Mode and count registers of one endpoint
`timescale 1ns/10ps
`include "uem_defines.vh"

module uem_ep_regs (
  input  wire       i_mclk,
  input  wire       i_sys_rst,
  input  wire       i_cpu_wr_mode,
  input  wire       i_cpu_wr_cnt,
  input  wire [7:0] i_wdata,
  input  wire       i_hw_mode_ld,
  input  wire [3:0] i_hw_mode,
  input  wire [3:0] i_hw_stat,
  input  wire       i_hw_cnt_ld,
  input  wire [3:0] i_hw_cnt,
  input  wire       i_hw_tog,
  input  wire       i_hw_dval,
  output reg  [7:0] o_mode_reg,
  output reg  [7:0] o_cnt_reg
);

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mode_reg <= `UEM_RST_MODE;
      o_cnt_reg  <= `UEM_RST_CNT;
    end else begin
      // Engine updates win over a colliding CPU write
      if (i_hw_mode_ld) begin
        o_mode_reg[3:0] <= i_hw_mode;
      end else if (i_cpu_wr_mode) begin
        o_mode_reg[3:0] <= i_wdata[3:0];
      end
      o_mode_reg[7:4] <= i_hw_stat |
                         (i_cpu_wr_mode ? i_wdata[7:4] : o_mode_reg[7:4]);
      if (i_hw_cnt_ld) begin
        o_cnt_reg <= {i_hw_tog, i_hw_dval, 2'b00, i_hw_cnt};
      end else if (i_cpu_wr_cnt) begin
        o_cnt_reg <= {i_wdata[7:6], 2'b00, i_wdata[3:0]};
      end
    end
  end

endmodule // uem_ep_regs

// File: design/uem_lock.v
// Endpoint-0 write interlock
`timescale 1ns/10ps
`include "uem_defines.vh"

module uem_lock (
  input  wire i_mclk,
  input  wire i_sys_rst,
  input  wire i_set,
  input  wire i_rd,
  input  wire i_busy,
  output reg  o_locked
);

  reg locked_next;

  // Set wins over a release read in the same cycle
  always @* begin
    locked_next = o_locked;
    if (i_rd && !i_busy) begin
      locked_next = 1'b0;
    end
    if (i_set) begin
      locked_next = 1'b1;
    end
  end

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_locked <= 1'b0;
    end else begin
      o_locked <= locked_next;
    end
  end

endmodule // uem_lock

// File: tb/test_usb_endpoint_mode_engine.sv
// Bench for the endpoint mode engine
`timescale 1ns/10ps
`include "uem_defines.vh"

module test_usb_endpoint_mode_engine;
  reg        i_mclk;
  reg        i_sys_rst;
  reg  [3:0] reg_addr;
  reg  [7:0] reg_wdata;
  reg        reg_wr;
  reg        reg_rd;
  wire       tok_stb, dat_start, dat_stb, dat_ok, dat_tog, hs_stb, hs_ack;
  wire       resp_stb, lock_lvl;
  wire [1:0] tok_pid, tok_ep;
  wire [3:0] dat_cnt, tx_len;
  wire [2:0] resp_code, ep_int;
  wire [7:0] rdata;
  reg  [7:0] rd_val;
  reg  [2:0] got_code, got_int;
  reg  [3:0] got_len;
  reg        got_stb;
  integer    fail_count, checked, i;

  uem_host u_host (.i_mclk(i_mclk), .o_tok_stb(tok_stb), .o_tok_pid(tok_pid),
    .o_tok_ep(tok_ep), .o_dat_start(dat_start), .o_dat_stb(dat_stb), .o_dat_cnt(dat_cnt),
    .o_dat_ok(dat_ok), .o_dat_tog(dat_tog), .o_hs_stb(hs_stb), .o_hs_ack(hs_ack));

  uem_engine #(.EP_NUM(3)) u_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_tok_stb(tok_stb), .i_tok_pid(tok_pid), .i_tok_ep(tok_ep), .i_dat_start(dat_start),
    .i_dat_stb(dat_stb), .i_dat_cnt(dat_cnt), .i_dat_ok(dat_ok), .i_dat_tog(dat_tog),
    .i_hs_stb(hs_stb), .i_hs_ack(hs_ack), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata), .o_resp_stb(resp_stb),
    .o_resp_code(resp_code), .o_tx_len(tx_len), .o_ep_int(ep_int), .o_ep0_locked(lock_lvl));

  // ======
  task check(input [7:0] seen, input [7:0] exp, input [8*16-1:0] what);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask

  task end_sim;
    begin
      $display("checked %0d failed %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task wr(input [3:0] a, input [7:0] d);
    @(posedge i_mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge i_mclk);
    reg_wr    <= 1'b0;
  endtask

  task rd(input [3:0] a);
    @(posedge i_mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge i_mclk);
    reg_rd   <= 1'b0;
    #1 rd_val = rdata;
  endtask

  task txn(input [1:0] ep, input [1:0] pid, input [3:0] n, input ok, input tog);
    u_host.token(pid, ep);
    if (pid != `UEM_PID_IN)
      u_host.data(n, ok, tog);
    #1 got_stb = resp_stb;
    got_code = resp_code;
    got_len  = tx_len;
    got_int  = ep_int;
  endtask

  // Code 0 means no response strobe may come back
  task resp(input [2:0] c, input [3:0] n);
    check(got_stb, c != 3'h0, "resp_stb");
    if (c != 3'h0)
      check(got_code, c, "resp_code");
    if (c >= `UEM_R_TX0)
      check(got_len, n, "tx_len");
  endtask

  // ======
  task t_reset;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        rd(i[3:0]);
        check(rd_val, `UEM_RST_MODE, "reset reg");
      end
      txn(2'h0, `UEM_PID_SETUP, 4'hA, 1'b1, 1'b0);
      resp(3'h0, 4'h0);
      check(got_int, 8'h00, "disabled int");
    end
  endtask

  task t_setup;
    begin
      wr(`UEM_A_MODE0, {4'h0, `UEM_M_STALL_IO});
      txn(2'h0, `UEM_PID_SETUP, 4'hA, 1'b1, 1'b0);
      resp(`UEM_R_ACK, 4'h0);
      check(got_int, 8'h01, "ep0 int");
      check(lock_lvl, 8'h01, "lock set");
      wr(`UEM_A_MODE0, 8'h09);
      wr(`UEM_A_CNT0, 8'h05);
      rd(`UEM_A_MODE0);
      check(rd_val, 8'h91, "mode0");
      check(lock_lvl, 8'h00, "lock free");
      rd(`UEM_A_CNT0);
      check(rd_val, 8'h4A, "cnt0");
      wr(`UEM_A_MODE0, 8'h0D);
      rd(`UEM_A_MODE0);
      check(rd_val, 8'h0D, "mode0 write");
    end
  endtask

  task t_bad;
    begin
      wr(4'h1, {4'h0, `UEM_M_STAT_OUT});
      txn(2'h1, `UEM_PID_SETUP, 4'hB, 1'b1, 1'b1);
      resp(3'h0, 4'h0);
      check(got_int, 8'h02, "bad int");
      rd(4'h1);
      check(rd_val, 8'h82, "mode kept");
      rd(4'h5);
      check(rd_val, 8'h8B, "cnt big");
      txn(2'h1, `UEM_PID_SETUP, 4'h4, 1'b0, 1'b0);
      resp(3'h0, 4'h0);
      rd(4'h5);
      check(rd_val, 8'h04, "cnt bad crc");
    end
  endtask

  task t_in;
    begin
      wr(4'h5, 8'h04);
      wr(4'h1, {4'h0, `UEM_M_ACK_IN});
      txn(2'h1, `UEM_PID_IN, 4'h0, 1'b0, 1'b0);
      resp(`UEM_R_TXCNT, 4'h4);
      rd(4'h1);
      check(rd_val, 8'h0D, "mode before hs");
      u_host.hshake(1'b1);
      #1 check(ep_int, 8'h02, "in int");
      rd(4'h1);
      check(rd_val, 8'h5C, "mode after hs");
      wr(4'h1, {4'h0, `UEM_M_ISO_IN});
      txn(2'h1, `UEM_PID_IN, 4'h0, 1'b0, 1'b0);
      resp(`UEM_R_TXCNT, 4'h4);
    end
  endtask

  task t_out;
    begin
      wr(4'h2, {4'h0, `UEM_M_ACK_OUT});
      txn(2'h2, `UEM_PID_OUT, 4'h5, 1'b1, 1'b1);
      resp(`UEM_R_ACK, 4'h0);
      check(got_int, 8'h04, "out int");
      rd(4'h2);
      check(rd_val, 8'h38, "mode after ack");
      rd(4'h6);
      check(rd_val, 8'hC5, "cnt out");
      txn(2'h2, `UEM_PID_OUT, 4'h5, 1'b1, 1'b0);
      resp(`UEM_R_NAK, 4'h0);
    end
  endtask

  // Row nibbles: token, mode, count, toggle, answer, next mode
  task row(input [23:0] r);
    wr(4'h2, {4'h0, r[19:16]});
    txn(2'h2, r[21:20], r[15:12], 1'b1, r[8]);
    resp(r[6:4], 4'h0);
    rd(4'h2);
    check(rd_val[3:0], r[3:0], "next mode");
  endtask

  task t_table;
    begin
      row(24'h312121);
      row(24'h322112);
      row(24'h322033);
      row(24'h332133);
      row(24'h342104);
      row(24'h362133);
      row(24'h382128);
      row(24'h3B211A);
      row(24'h3C210C);
      row(24'h3E3133);
      row(24'h3F211F);
      row(24'h302100);
      row(24'h210021);
      row(24'h220033);
      row(24'h240004);
      row(24'h260046);
      row(24'h280008);
      row(24'h2A004A);
      row(24'h2E002E);
      row(24'h12A011);
      row(24'h14A011);
      row(24'h16A011);
      row(24'h1BA011);
      row(24'h1FA011);
      row(24'h15A005);
      row(24'h18A008);
    end
  endtask

  // ======
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  initial begin
    #(100000 * 100);
    fail_count = fail_count + 1;
    end_sim;
  end

  initial begin
    fail_count = 0;
    checked    = 0;
    i_sys_rst  = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 14'h0000;
    repeat (20) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_reset;
    t_setup;
    t_bad;
    t_in;
    t_out;
    t_table;
    end_sim;
  end
endmodule // test_usb_endpoint_mode_engine

// File: tb/uem_engine_assertions.sv
// Assertions on the engine ports
`timescale 1ns/10ps
`include "uem_defines.vh"

module uem_chk #(
  parameter EP_NUM = 3
) (
  input wire              i_mclk,
  input wire              i_sys_rst,
  input wire              i_tok_stb,
  input wire [1:0]        i_tok_pid,
  input wire              i_dat_stb,
  input wire [3:0]        i_dat_cnt,
  input wire              i_dat_ok,
  input wire              i_hs_stb,
  input wire              i_hs_ack,
  input wire              i_reg_rd,
  input wire              o_resp_stb,
  input wire [2:0]        o_resp_code,
  input wire [3:0]        o_tx_len,
  input wire [EP_NUM-1:0] o_ep_int,
  input wire              o_ep0_locked
);
  reg [1:0] last_pid_reg;

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst)
      last_pid_reg <= 2'h0;
    else if (i_tok_stb)
      last_pid_reg <= i_tok_pid;
  end

  // ======
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  reset_quiet_a: assert property ($fell(i_sys_rst) |-> !o_resp_stb && !o_ep0_locked)
    else $error("busy after reset");
  resp_cause_a: assert property (o_resp_stb |-> $past(i_tok_stb && i_tok_pid == `UEM_PID_IN)
    || $past(i_dat_stb && i_dat_ok && i_dat_cnt <= `UEM_MAX_PKT))
    else $error("unprompted response");
  bad_data_a: assert property (i_dat_stb && (!i_dat_ok || i_dat_cnt > `UEM_MAX_PKT)
    |=> !o_resp_stb)
    else $error("bad packet answered");
  setup_ack_a: assert property (i_dat_stb && last_pid_reg == `UEM_PID_SETUP
    |=> !o_resp_stb || o_resp_code == `UEM_R_ACK)
    else $error("setup not acked");
  out_wait_a: assert property (i_tok_stb && i_tok_pid != `UEM_PID_IN |=> !o_resp_stb)
    else $error("early answer");
  tx0_len_a: assert property (o_resp_stb && o_resp_code == `UEM_R_TX0
    |-> o_tx_len == 4'h0)
    else $error("tx0 length");
  lock_set_a: assert property ($rose(o_ep0_locked) |-> (o_resp_stb && o_resp_code == `UEM_R_ACK)
    || $past(i_hs_stb && i_hs_ack))
    else $error("lock without ack");
  lock_free_a: assert property ($fell(o_ep0_locked) |-> $past(i_reg_rd))
    else $error("lock freed unread");
  int_cause_a: assert property (o_ep_int != 3'h0
    |-> $past(i_tok_stb || i_dat_stb || i_hs_stb))
    else $error("stray interrupt");

  cover property (o_resp_stb && o_resp_code == `UEM_R_TXCNT);
  cover property ($rose(o_ep0_locked));
  cover property (o_resp_stb && o_resp_code == `UEM_R_STALL);
endmodule // uem_chk

bind uem_engine uem_chk #(.EP_NUM(EP_NUM)) u_chk (.*);

// File: tb/uem_host.sv
// Host model: token, data and handshake strobes
`timescale 1ns/10ps

module uem_host (
  input  wire       i_mclk,
  output reg        o_tok_stb,
  output reg  [1:0] o_tok_pid,
  output reg  [1:0] o_tok_ep,
  output reg        o_dat_start,
  output reg        o_dat_stb,
  output reg  [3:0] o_dat_cnt,
  output reg        o_dat_ok,
  output reg        o_dat_tog,
  output reg        o_hs_stb,
  output reg        o_hs_ack
);
  initial begin
    {o_tok_stb, o_dat_start, o_dat_stb, o_hs_stb} = 4'h0;
    {o_tok_pid, o_tok_ep, o_dat_cnt, o_dat_ok, o_dat_tog, o_hs_ack} = 10'h000;
  end

  // ======
  // Qualifiers are scrambled once the strobe drops
  task token(input [1:0] pid, input [1:0] ep);
    @(posedge i_mclk);
    o_tok_stb <= 1'b1;
    {o_tok_pid, o_tok_ep} <= {pid, ep};
    @(posedge i_mclk);
    o_tok_stb <= 1'b0;
    {o_tok_pid, o_tok_ep} <= ~{pid, ep};
  endtask

  task data(input [3:0] cnt, input ok, input tog);
    @(posedge i_mclk);
    o_dat_start <= 1'b1;
    @(posedge i_mclk);
    o_dat_start <= 1'b0;
    o_dat_stb   <= 1'b1;
    {o_dat_cnt, o_dat_ok, o_dat_tog} <= {cnt, ok, tog};
    @(posedge i_mclk);
    o_dat_stb   <= 1'b0;
    {o_dat_cnt, o_dat_ok, o_dat_tog} <= ~{cnt, ok, tog};
  endtask

  task hshake(input ack);
    @(posedge i_mclk);
    o_hs_stb <= 1'b1;
    o_hs_ack <= ack;
    @(posedge i_mclk);
    o_hs_stb <= 1'b0;
    o_hs_ack <= ~ack;
  endtask
endmodule // uem_host
